// ===== rtl/spi_out_pkg.sv
// Purpose: Constants for the serial output datagram formatter
// Assumes: 100 MHz system clock, master drives the serial link
// Notes: Format codes and configuration bit positions live here
package spi_out_pkg;
    // Output format codes
    localparam logic [3:0] FMT_OFF = 4'h0;
    localparam logic [3:0] FMT_DAC_MAPPED = 4'h1;
    localparam logic [3:0] FMT_DAC_ABS_N = 4'h2;
    localparam logic [3:0] FMT_DAC_ABS_P = 4'h3;
    localparam logic [3:0] FMT_SCALE = 4'h4;
    localparam logic [3:0] FMT_SIGNED = 4'h5;
    localparam logic [3:0] FMT_DAC_SCALE = 4'h6;
    localparam logic [3:0] FMT_COVER = 4'hf;
    // Configuration bit positions in serial_out_configuration
    localparam int CFG_SCK_LOW_BIT = 4;
    localparam int CFG_RISE_BIT = 5;
    // Widths of the length field and of payloads
    localparam int LEN_W = 6;
    localparam int SCALE_W = 8;
    localparam int CUR_W = 9;
    localparam int SIGNED_W = 18;
    // Half period of the serial clock, in ns, and in cycles
    localparam int HALF_NS = 500;
    localparam int CLK_NS = 10;
    localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
    // Reset value of the length register
    localparam logic [LEN_W-1:0] LEN_RESET = 6'h08;
endpackage

// ===== rtl/spi_output_dac_formatter.sv
// Purpose: Serial master sending scale and coil current datagrams
// Assumes: Values and config come from logic on the same clock
// Notes: No address prefix; cover datagrams come in as a request
`timescale 1ns/100ps
module spi_output_dac_formatter
    import spi_out_pkg::*;
#(
    parameter int HALF = spi_out_pkg::HALF_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] output_format,
    input wire logic [7:0] serial_out_configuration,
    input wire logic [spi_out_pkg::LEN_W-1:0] datagram_length,
    input wire logic [spi_out_pkg::SCALE_W-1:0] current_scale_factor,
    input wire logic [spi_out_pkg::CUR_W-1:0] coil_a_current_value,
    input wire logic [spi_out_pkg::CUR_W-1:0] coil_b_current_value,
    input wire logic cover_request,
    input wire logic [63:0] cover_data,
    output logic cover_taken,
    output logic busy,
    output logic out_chip_select_n,
    output logic out_serial_clock,
    output logic out_serial_data,
    output logic out_drive_enable
);
    import spi_out_pkg::*;

    typedef enum {IDLE, SETUP, LEAD, SHIFT_LO, SHIFT_HI, TAIL, GAP} state_e;

    state_e state; // Link sequencer state
    logic [7:0] tmr; // Half-period timer
    logic [LEN_W-1:0] bits_left; // Clock pulses still due
    logic [63:0] shreg; // Shift register, MSB leaves first
    logic second_due; // Coil B datagram still owed
    logic [SCALE_W-1:0] last_scale; // Last seen scale factor
    logic [CUR_W-1:0] last_a; // Last seen coil A value
    logic [CUR_W-1:0] last_b; // Last seen coil B value
    logic scale_pend; // Scale change waiting
    logic cur_pend; // Current change waiting
    logic cfg_sck_low; // Clock idles low around select
    logic cfg_rise; // Data changes on rising edge
    logic cover_fmt; // Cover-only format
    logic dac_cur_fmt; // Two-datagram converter formats
    logic scale_fmt; // Single scale datagram formats
    logic tick; // Timer expiry

    // Native framing only in cover-only format
    assign cover_fmt = (output_format == FMT_COVER);
    assign cfg_sck_low = serial_out_configuration[CFG_SCK_LOW_BIT] & ~cover_fmt;
    assign cfg_rise = serial_out_configuration[CFG_RISE_BIT] & ~cover_fmt;
    assign dac_cur_fmt = (output_format == FMT_DAC_MAPPED) ||
                         (output_format == FMT_DAC_ABS_N) ||
                         (output_format == FMT_DAC_ABS_P);
    assign scale_fmt = (output_format == FMT_SCALE) || (output_format == FMT_DAC_SCALE);
    assign tick = (tmr == 8'h00);
    assign busy = (state != IDLE);
    assign out_drive_enable = (output_format != FMT_OFF);
    assign cover_taken = (state == IDLE) && cover_fmt && cover_request;

    // Payload placed right-justified then moved to the top of the frame
    function automatic logic [63:0] frame(input logic [63:0] val, input logic [LEN_W-1:0] n);
        frame = val << (7'd64 - {1'b0, n});
    endfunction

    // Change detection, held pending until the link is free
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_scale <= 8'h00;
            last_a <= 9'h000;
            last_b <= 9'h000;
            scale_pend <= 1'b0;
            cur_pend <= 1'b0;
        end
        else
        begin
            last_scale <= current_scale_factor;
            last_a <= coil_a_current_value;
            last_b <= coil_b_current_value;
            // Set wins over clear taken at start of a datagram
            if (last_scale != current_scale_factor)
                scale_pend <= 1'b1;
            else if (state == IDLE && scale_fmt && !second_due)
                scale_pend <= 1'b0;
            if (last_a != coil_a_current_value || last_b != coil_b_current_value)
                cur_pend <= 1'b1;
            // A coil B start must not swallow a change seen during coil A
            else if (state == IDLE && !second_due &&
                     (dac_cur_fmt || output_format == FMT_SIGNED))
                cur_pend <= 1'b0;
        end
    end

    // Link sequencer: select, clock and data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= IDLE;
            tmr <= 8'h00;
            bits_left <= '0;
            shreg <= 64'h0;
            second_due <= 1'b0;
            out_chip_select_n <= 1'b1;
            out_serial_clock <= 1'b1;
            out_serial_data <= 1'b0;
        end
        else
        begin
            tmr <= tick ? 8'h00 : tmr - 8'h01;
            case (state)
                IDLE:
                begin
                    out_chip_select_n <= 1'b1;
                    out_serial_clock <= ~cfg_sck_low;
                    bits_left <= datagram_length;
                    tmr <= 8'(HALF - 1);
                    if (second_due)
                    begin
                        shreg <= frame(64'(coil_b_current_value), datagram_length);
                        second_due <= 1'b0;
                        state <= SETUP;
                    end
                    else if (cover_fmt && cover_request)
                    begin
                        shreg <= cover_data;
                        state <= SETUP;
                    end
                    // Pending flag only: a live compare here would resend the same value
                    else if (scale_fmt && scale_pend)
                    begin
                        // Zero padding comes from the shift left of a narrow value
                        shreg <= frame(64'(current_scale_factor), datagram_length);
                        state <= SETUP;
                    end
                    else if (output_format == FMT_SIGNED && cur_pend)
                    begin
                        shreg <= frame(64'({coil_a_current_value, coil_b_current_value}),
                                       datagram_length);
                        state <= SETUP;
                    end
                    else if (dac_cur_fmt && cur_pend)
                    begin
                        shreg <= frame(64'(coil_a_current_value), datagram_length);
                        second_due <= 1'b1;
                        state <= SETUP;
                    end
                end
                SETUP:
                begin
                    // Select goes low while clock still idles
                    out_chip_select_n <= 1'b0;
                    out_serial_data <= shreg[63];
                    if (tick)
                    begin
                        // One extra count so the first low phase is a full half period
                        tmr <= 8'(HALF);
                        state <= SHIFT_LO;
                    end
                end
                SHIFT_LO:
                begin
                    // Clock low phase, data updated on falling edge by default
                    out_serial_clock <= 1'b0;
                    if (tick)
                    begin
                        tmr <= 8'(HALF - 1);
                        out_serial_clock <= 1'b1;
                        if (cfg_rise)
                        begin
                            out_serial_data <= shreg[62];
                        end
                        state <= SHIFT_HI;
                    end
                end
                SHIFT_HI:
                begin
                    if (tick)
                    begin
                        tmr <= 8'(HALF - 1);
                        shreg <= {shreg[62:0], 1'b0};
                        bits_left <= bits_left - 1'b1;
                        if (bits_left <= 1)
                            state <= TAIL;
                        else
                        begin
                            out_serial_clock <= 1'b0;
                            if (!cfg_rise)
                                out_serial_data <= shreg[62];
                            state <= SHIFT_LO;
                        end
                    end
                end
                TAIL:
                begin
                    // Clock already high, select released after a half period
                    if (tick)
                    begin
                        // Clock stays high here; a fall now would be a stray edge
                        out_chip_select_n <= 1'b1;
                        tmr <= 8'(HALF - 1);
                        state <= GAP;
                    end
                end
                GAP:
                begin
                    // Clock returns to its idle level only once select is high
                    out_serial_clock <= ~cfg_sck_low;
                    if (tick)
                        state <= IDLE;
                end
                default:
                    state <= IDLE;
            endcase
        end
    end

    // Select must never fall while the clock is in its active low phase
    chk_select_order: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(out_chip_select_n) |-> (out_serial_clock == ~cfg_sck_low))
        else $error("select fell with wrong clock level");

    // Clock must be high when select rises
    chk_release_order: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(out_chip_select_n) |-> (out_serial_clock && $past(out_serial_clock)))
        else $error("select rose while clock low");

    // Idle clock low when clock-low option on
    chk_idle_low: assert property (@(posedge clk) disable iff (!rst_n)
        (state == GAP && $past(state) == GAP && cfg_sck_low &&
         $stable(serial_out_configuration) && $stable(output_format)) |->
        !out_serial_clock)
        else $error("clock not low at idle");

    // Default mode keeps data stable across rising clock edge
    chk_fall_shift: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(out_serial_clock) && !out_chip_select_n && !cfg_rise) |-> $stable(out_serial_data))
        else $error("data changed on rising edge");

    // Rising mode keeps data stable across falling clock edge after first bit
    chk_rise_shift: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(out_serial_clock) && state == SHIFT_LO && $past(state) == SHIFT_HI && cfg_rise)
        |-> $stable(out_serial_data))
        else $error("data changed on falling edge");

    // Coil A datagram is followed by coil B datagram
    chk_second_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (state == GAP && second_due && tick) |=> (state == IDLE) ##1 (state == SETUP))
        else $error("second datagram not started");

    // Cover-only format never sends a value datagram on its own
    chk_cover_only: assert property (@(posedge clk) disable iff (!rst_n)
        (state == IDLE && cover_fmt && !cover_request && !second_due) |=> (state == IDLE))
        else $error("value datagram in cover-only format");

    // Drivers off in format zero
    chk_drive_off: assert property (@(posedge clk) disable iff (!rst_n)
        (output_format == FMT_OFF) |-> !out_drive_enable)
        else $error("drivers on in off format");

    // Bit count never underflows during a frame
    chk_bit_count: assert property (@(posedge clk) disable iff (!rst_n)
        (state == SHIFT_HI && tick && bits_left <= 1) |=> (state == TAIL))
        else $error("frame length wrong");
endmodule // spi_output_dac_formatter

// ===== bench/dac_receiver_model.sv
// Purpose: Receiver model of a converter on the formatter's serial output
// Assumes: Select active low, one bit taken per clock pulse
// Notes: Each finished datagram is queued for the bench to pop
`timescale 1ns/100ps
module dac_receiver_model
(
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sample_on_fall
);
    logic [63:0] shift = '0; // Bits taken so far
    int nbits = 0; // Bit count of this frame
    logic at_fall; // Clock level when select fell
    logic [63:0] words[$]; // Finished datagrams
    int counts[$]; // Bits per datagram
    logic [1:0] lvls[$]; // Clock level at select fall and rise
    // New frame clears the shifter
    always @(negedge cs_n)
    begin
        shift = '0;
        nbits = 0;
        at_fall = sclk;
    end
    // Take a bit on the sampling edge this converter uses
    always @(sclk)
    begin
        if (cs_n === 1'b0 && sclk === !sample_on_fall)
        begin
            shift = {shift[62:0], sdo};
            nbits++;
        end
    end
    // Frame end; empty frames from reset are skipped
    always @(posedge cs_n)
    begin
        if (nbits > 0)
        begin
            words.push_back(shift);
            counts.push_back(nbits);
            lvls.push_back({at_fall, sclk});
            nbits = 0;
        end
    end
endmodule // dac_receiver_model

// ===== bench/tb.sv
// Purpose: Self-checking bench for the serial datagram formatter
// Assumes: Half period shortened to 2 cycles
// Notes: Datagrams are judged through the receiver model's queues
`timescale 1ns/100ps
module tb;
    import spi_out_pkg::*;
    logic clk, rst_n, cover_request, rx_fall; // Clock, reset, cover strobe, model mode
    logic [3:0] output_format;
    logic [7:0] serial_out_configuration;
    logic [LEN_W-1:0] datagram_length;
    logic [SCALE_W-1:0] current_scale_factor;
    logic [CUR_W-1:0] coil_a_current_value, coil_b_current_value;
    logic [63:0] cover_data;
    logic cover_taken, busy, out_chip_select_n, out_serial_clock, out_serial_data, out_drive_enable;
    int n_mismatch = 0;
    int checks_done = 0;
    spi_output_dac_formatter #(.HALF(2)) dut (.clk(clk), .rst_n(rst_n),
        .output_format(output_format), .serial_out_configuration(serial_out_configuration),
        .datagram_length(datagram_length), .current_scale_factor(current_scale_factor),
        .coil_a_current_value(coil_a_current_value),
        .coil_b_current_value(coil_b_current_value), .cover_request(cover_request),
        .cover_data(cover_data), .cover_taken(cover_taken), .busy(busy),
        .out_chip_select_n(out_chip_select_n), .out_serial_clock(out_serial_clock),
        .out_serial_data(out_serial_data), .out_drive_enable(out_drive_enable));
    dac_receiver_model rx (.cs_n(out_chip_select_n), .sclk(out_serial_clock),
        .sdo(out_serial_data), .sample_on_fall(rx_fall));
    // Single compare for every result
    task automatic cmp_val(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Mode change while idle
    task automatic setup(input logic [3:0] f, input logic [7:0] c, input int len, input logic fl);
        for (int k = 0; k < 500 && busy !== 1'b0; k++)
            @(posedge clk);
        // Link never went idle
        if (busy !== 1'b0)
        begin
            n_mismatch++;
            summarize();
        end
        output_format <= f;
        serial_out_configuration <= c;
        datagram_length <= len[LEN_W-1:0];
        rx_fall <= fl;
        repeat (4) @(posedge clk);
    endtask
    // Wait for one datagram and judge it
    task automatic expect_frame(input string nm, input logic [63:0] w, input int n,
        input logic [1:0] lv, input logic [1:0] mk);
        int k;
        for (k = 0; k < 3000 && rx.words.size() == 0; k++)
            @(posedge clk);
        if (k == 3000)
        begin
            n_mismatch++;
            summarize();
        end
        cmp_val(nm, w, rx.words.pop_front());
        cmp_val("bit count", 64'(n), 64'(rx.counts.pop_front()));
        cmp_val("clock at select", 64'(lv & mk), 64'(rx.lvls.pop_front() & mk));
    endtask
    // No further datagram may appear
    task automatic expect_quiet();
        repeat (300) @(posedge clk);
        cmp_val("extra frames", 64'h0, 64'(rx.words.size()));
    endtask
    task automatic t_scale();
        setup(FMT_SCALE, 8'h00, 12, 1'b0);
        current_scale_factor <= 8'ha5;
        expect_frame("scale word", 64'h0a5, 12, 2'b11, 2'b11);
        expect_quiet();
        cmp_val("drive enable", 64'h1, 64'(out_drive_enable));
    endtask
    task automatic t_midframe();
        setup(FMT_SCALE, 8'h00, 8, 1'b0);
        current_scale_factor <= 8'h11;
        for (int k = 0; k < 200 && out_chip_select_n !== 1'b0; k++)
            @(posedge clk);
        // Frame never started
        if (out_chip_select_n !== 1'b0)
        begin
            n_mismatch++;
            summarize();
        end
        current_scale_factor <= 8'h22;
        repeat (3) @(posedge clk);
        current_scale_factor <= 8'h33;
        expect_frame("first scale", 64'h11, 8, 2'b11, 2'b11);
        expect_frame("latest scale", 64'h33, 8, 2'b11, 2'b11);
        expect_quiet();
    endtask
    task automatic t_sck_low();
        setup(FMT_SCALE, 8'h10, 8, 1'b0);
        current_scale_factor <= 8'hc3;
        expect_frame("scale clock low", 64'hc3, 8, 2'b01, 2'b11);
    endtask
    task automatic t_signed(input logic [7:0] c, input logic fl, input logic [8:0] a,
        input logic [8:0] b, input int len);
        setup(FMT_SIGNED, c, len, fl);
        coil_a_current_value <= a;
        coil_b_current_value <= b;
        expect_frame("signed word", 64'({a, b}), len, 2'b11, 2'b11);
        expect_quiet();
    endtask
    task automatic t_pair();
        for (int i = 1; i <= 3; i++)
        begin
            setup(i[3:0], 8'h00, 9, 1'b0);
            coil_a_current_value <= 9'h0f0 + i[8:0];
            expect_frame("coil a", 64'h0f0 + i, 9, 2'b11, 2'b11);
            expect_frame("coil b", 64'h0d3, 9, 2'b11, 2'b11);
            expect_quiet();
        end
    endtask
    task automatic t_cover();
        setup(FMT_COVER, 8'h30, 16, 1'b0);
        cover_data <= 64'habcd_0000_0000_0000;
        cover_request <= 1'b1;
        for (int k = 0; k < 200 && cover_taken !== 1'b1; k++)
            @(negedge clk);
        // Cover request never accepted
        if (cover_taken !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
        @(posedge clk);
        cover_request <= 1'b0;
        expect_frame("cover word", 64'habcd, 16, 2'b11, 2'b11);
        current_scale_factor <= 8'h5a;
        coil_a_current_value <= 9'h001;
        expect_quiet();
    endtask
    task automatic t_off();
        setup(FMT_OFF, 8'h00, 8, 1'b0);
        cmp_val("drive enable", 64'h0, 64'(out_drive_enable));
    endtask
    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        {cover_request, rx_fall, output_format, serial_out_configuration} = '0;
        datagram_length = 6'h08;
        {current_scale_factor, coil_a_current_value, coil_b_current_value} = '0;
        cover_data = 64'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_scale();
        t_midframe();
        t_sck_low();
        t_signed(8'h00, 1'b0, 9'h1ab, 9'h055, 20);
        t_signed(8'h20, 1'b1, 9'h12c, 9'h0d3, 18);
        t_pair();
        t_cover();
        t_off();
        summarize();
    end
endmodule // tb
